// *** ascp_map.vh ***
// Purpose: Constants for the serial control and result port of the converter.
// Assumes: 10 MHz system clock, shift clock sampled as a plain input.
// Notes: Definitions only.
`ifndef ASCP_MAP_VH
`define ASCP_MAP_VH
`define ASCP_CMD_W 8
`define ASCP_RES_W 12
`define ASCP_ADDR_MSB 7
`define ASCP_ADDR_LSB 4
`define ASCP_LEN_HI 3
`define ASCP_LEN_LO 2
`define ASCP_LOW_FIRST_BIT 1
`define ASCP_SIGNED_BIT 0
`define ASCP_CMD_RESET 8'h00
`define ASCP_LEN_8 2'h1
`define ASCP_LEN_16 2'h3
`define ASCP_SAMPLE_EDGE 5'h04
`define ASCP_CLK_HZ 10000000
`define ASCP_CONV_US 10
`define ASCP_CONV_CYC ((`ASCP_CONV_US * `ASCP_CLK_HZ) / 1000000)
`define ASCP_SETUP_NS 1000
`define ASCP_SETUP_CYC ((`ASCP_SETUP_NS * (`ASCP_CLK_HZ / 1000000) + 999) / 1000)
`define ASCP_ABORT_US 5
`define ASCP_ABORT_CYC ((`ASCP_ABORT_US * `ASCP_CLK_HZ) / 1000000)
`define ASCP_ADDR_PDOWN 4'he
`endif

// *** ascp_sync.v ***
// Purpose: Two-flop synchroniser for one level from outside the clock domain.
// Assumes: Synchronous active-high reset.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module ascp_sync #(
  parameter RESET_VAL = 1'b0
) (
  input wire clk_i,
  input wire rst_i,
  input wire d_i,
  output reg q_o
);
  reg meta_reg;

  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= RESET_VAL;
      q_o <= RESET_VAL;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule

// *** ascp_conv.v ***
// Purpose: Successive-approximation sequencer that produces one 12-bit result.
// Assumes: Analog comparison is supplied as a ready digital sample word.
// Notes: Runs from the system clock, started only by the serial port.
`timescale 1ns/1ps
`include "ascp_map.vh"
module ascp_conv #(
  parameter RES_W = 12,
  parameter CONV_CYC = 100
) (
  input wire clk_i,
  input wire rst_i,
  input wire start_i,
  input wire abort_i,
  input wire [RES_W-1:0] sample_i,
  output reg busy_o,
  output reg done_o,
  output reg [RES_W-1:0] result_o
);
  reg [15:0] cnt_reg;
  reg [RES_W-1:0] held_reg;

  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 16'h0000;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      result_o <= {RES_W{1'b0}};
      held_reg <= {RES_W{1'b0}};
    end else begin
      done_o <= 1'b0;
      if (abort_i) begin
        busy_o <= 1'b0;
      end else if (start_i && !busy_o) begin
        busy_o <= 1'b1;
        held_reg <= sample_i;
        cnt_reg <= CONV_CYC[15:0] - 16'h0001;
      end else if (busy_o) begin
        if (cnt_reg == 16'h0000) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
          result_o <= held_reg;
        end else begin
          cnt_reg <= cnt_reg - 16'h0001;
        end
      end
    end
  end
endmodule

// *** ascp_port.v ***
// Purpose: Serial command and result port of a 12-bit converter, device side.
// Assumes: Select, shift clock and command input come from another domain.
// Notes: Analog front end is modelled by a digital sample word per channel.
//
// Overview of operation
// - Select high: ignore clock and command input, result output released.
// - Select falling edge starts a new sequence and enables the output.
// - Command: address D7-D4, length D3-D2, bit order D1, polarity D0.
// - Command bits taken on rising clock edges of the first eight clocks only.
// - A cycle has exactly 8, 12 or 16 clock periods per length code.
// - Sampling starts at the fourth falling edge, held after the last.
// - Last falling edge drives done low and starts conversion.
// - Select held low: first result bit appears when done rises.
// - Select toggled: first result bit appears at select falling edge.
// - Each later result bit is driven on each following falling edge.
// - Conversion is timed internally; done rises once result is loaded.
// - Conversion never starts before the current cycle has finished.
// - At power-up done is high and the command register is zero.
// - Raising then lowering select resynchronises to a fresh cycle.
// - Result loads at completion and shifts out next cycle.
// - Twelve-bit mode cycle has twelve clocks; conversion starts after twelfth.
// - Length code 00 or 10 is 12, 11 is 16, 01 is 8 bits.
// - Eight-bit drops four low bits; sixteen-bit appends four zero pads.
// - Address picks channel, test voltage or power-down for next conversion.
// - Select low within 5 us after tenth falling edge aborts conversion.
`timescale 1ns/1ps
`include "ascp_map.vh"
module ascp_port #(
  parameter RES_W = 12,
  parameter CONV_CYC = `ASCP_CONV_CYC,
  parameter SETUP_CYC = `ASCP_SETUP_CYC,
  parameter ABORT_CYC = `ASCP_ABORT_CYC
) (
  // System.
  input wire clk_i,
  input wire rst_i,
  // Serial link pins.
  input wire sel_n_i,
  input wire sclk_i,
  input wire cmd_i,
  output reg dout_o,
  output reg dout_oe_o,
  output reg done_o,
  // Analog stand-in: one sampled word for the selected source.
  input wire [RES_W-1:0] sample_i,
  output reg [3:0] chan_addr_o,
  output reg powered_down_o,
  output reg sampling_o
);
  localparam ST_IDLE = 3'b001;
  localparam ST_SETUP = 3'b010;
  localparam ST_IO = 3'b100;

  wire sel_n_s;
  wire sclk_s;
  wire cmd_s;
  wire conv_busy;
  wire conv_done;
  wire [RES_W-1:0] conv_result;

  reg [2:0] state_reg;
  reg sel_n_d_reg;
  reg sclk_d_reg;
  reg [7:0] cmd_reg;
  reg [7:0] shift_in_reg;
  reg [4:0] rise_cnt_reg;
  reg [4:0] fall_cnt_reg;
  reg [15:0] out_reg;
  reg [15:0] setup_cnt_reg;
  reg [15:0] abort_cnt_reg;
  reg abort_win_reg;
  reg start_reg;
  reg abort_reg;
  reg [1:0] len_now_reg;
  reg fmt_low_first_reg;
  reg fmt_signed_reg;

  // Edges are found one clock after the second synchroniser stage, so every
  // pin event is seen about three system clocks late; the host must allow for it.
  wire sclk_rise = sclk_s & ~sclk_d_reg;
  wire sclk_fall = ~sclk_s & sclk_d_reg;
  wire sel_fall = ~sel_n_s & sel_n_d_reg;

  ascp_sync #(.RESET_VAL(1'b1)) u_sync_sel (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(sel_n_i),
    .q_o(sel_n_s)
  );

  ascp_sync #(.RESET_VAL(1'b0)) u_sync_sclk (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(sclk_i),
    .q_o(sclk_s)
  );

  ascp_sync #(.RESET_VAL(1'b0)) u_sync_cmd (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(cmd_i),
    .q_o(cmd_s)
  );

  ascp_conv #(.RES_W(RES_W), .CONV_CYC(CONV_CYC)) u_conv (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(start_reg),
    .abort_i(abort_reg),
    .sample_i(sample_i),
    .busy_o(conv_busy),
    .done_o(conv_done),
    .result_o(conv_result)
  );

  // Number of clocks in a cycle for a length code.
  function [4:0] len_clocks;
    input [1:0] code;
    begin
      // Codes 00 and 10 both give twelve clocks.
      case (code)
        `ASCP_LEN_8: len_clocks = 5'h08;
        `ASCP_LEN_16: len_clocks = 5'h10;
        default: len_clocks = 5'h0c;
      endcase
    end
  endfunction

  // Result laid out as a 16-bit stream in shifting order.
  function [15:0] frame_result;
    input [RES_W-1:0] res;
    input [1:0] code;
    input low_first;
    input signed_fmt;
    reg [11:0] v;
    reg [15:0] msb_first;
    reg [15:0] rev;
    integer i;
    begin
      v = res[11:0];
      if (signed_fmt) begin
        v = {~res[11], res[10:0]};
      end
      msb_first = {v, 4'h0};
      rev = 16'h0000;
      // Eight-bit low-first keeps only the upper eight bits, lowest of them first.
      if (code == `ASCP_LEN_8) begin
        for (i = 0; i < 8; i = i + 1) begin
          rev[15-i] = v[4+i];
        end
      end else begin
        for (i = 0; i < 12; i = i + 1) begin
          rev[15-i] = v[i];
        end
      end
      if (low_first) begin
        frame_result = rev;
      end else begin
        frame_result = msb_first;
      end
    end
  endfunction

  // Stream for the next cycle, framed with the format bits of the cycle that
  // started this conversion; the top bit is the first one shifted out.
  wire [15:0] conv_frame = frame_result(conv_result, len_now_reg, fmt_low_first_reg,
                                        fmt_signed_reg);

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      sel_n_d_reg <= 1'b1;
      sclk_d_reg <= 1'b0;
      cmd_reg <= `ASCP_CMD_RESET;
      shift_in_reg <= 8'h00;
      rise_cnt_reg <= 5'h00;
      fall_cnt_reg <= 5'h00;
      out_reg <= 16'h0000;
      setup_cnt_reg <= 16'h0000;
      abort_cnt_reg <= 16'h0000;
      abort_win_reg <= 1'b0;
      start_reg <= 1'b0;
      abort_reg <= 1'b0;
      len_now_reg <= 2'h0;
      fmt_low_first_reg <= 1'b0;
      fmt_signed_reg <= 1'b0;
      dout_o <= 1'b0;
      dout_oe_o <= 1'b0;
      done_o <= 1'b1;
      chan_addr_o <= 4'h0;
      powered_down_o <= 1'b0;
      sampling_o <= 1'b0;
    end else begin
      sel_n_d_reg <= sel_n_s;
      sclk_d_reg <= sclk_s;
      start_reg <= 1'b0;
      abort_reg <= 1'b0;
      // The abort window opens at the tenth falling edge and closes on its own;
      // a select fall after it has closed leaves a running conversion alone.
      if (abort_win_reg) begin
        if (abort_cnt_reg == 16'h0000) begin
          abort_win_reg <= 1'b0;
        end else begin
          abort_cnt_reg <= abort_cnt_reg - 16'h0001;
        end
      end
      if (conv_done) begin
        out_reg <= conv_frame;
        done_o <= 1'b1;
        if (!sel_n_s) begin
          dout_o <= conv_frame[15];
        end
      end
      // Enable follows the synchronised select, so output release lags the pin.
      dout_oe_o <= ~sel_n_s;
      case (state_reg)
        ST_IDLE: begin
          if (sel_fall) begin
            state_reg <= ST_SETUP;
            setup_cnt_reg <= SETUP_CYC[15:0];
            dout_o <= out_reg[15];
            if (abort_win_reg && conv_busy) begin
              abort_reg <= 1'b1;
              done_o <= 1'b1;
              abort_win_reg <= 1'b0;
            end
          end else if (!sel_n_s && done_o && !conv_busy) begin
            // Select held low: the next cycle may only start once the result is loaded.
            state_reg <= ST_IO;
            rise_cnt_reg <= 5'h00;
            fall_cnt_reg <= 5'h00;
          end
        end
        ST_SETUP: begin
          // Clock and command edges inside the setup window are ignored, which keeps
          // select bounce from being taken as data.
          if (sel_n_s) begin
            state_reg <= ST_IDLE;
          end else if (setup_cnt_reg == 16'h0000) begin
            state_reg <= ST_IO;
            rise_cnt_reg <= 5'h00;
            fall_cnt_reg <= 5'h00;
          end else begin
            setup_cnt_reg <= setup_cnt_reg - 16'h0001;
          end
        end
        ST_IO: begin
          if (sel_n_s) begin
            // Select raised mid-cycle ends it; nothing is converted.
            state_reg <= ST_IDLE;
            sampling_o <= 1'b0;
          end else begin
            if (sclk_rise && rise_cnt_reg < 5'h08) begin
              shift_in_reg <= {shift_in_reg[6:0], cmd_s};
              rise_cnt_reg <= rise_cnt_reg + 5'h01;
              // The length is known after the sixth rising edge and applies at once.
              if (rise_cnt_reg == 5'h05) begin
                len_now_reg <= {shift_in_reg[0], cmd_s};
              end
              if (rise_cnt_reg == 5'h07) begin
                cmd_reg <= {shift_in_reg[6:0], cmd_s};
                fmt_low_first_reg <= shift_in_reg[0];
                fmt_signed_reg <= cmd_s;
              end
            end else if (sclk_rise) begin
              rise_cnt_reg <= rise_cnt_reg + 5'h01;
            end
            if (sclk_fall) begin
              fall_cnt_reg <= fall_cnt_reg + 5'h01;
              out_reg <= {out_reg[14:0], 1'b0};
              dout_o <= out_reg[14];
              if (fall_cnt_reg + 5'h01 == `ASCP_SAMPLE_EDGE) begin
                sampling_o <= 1'b1;
              end
              if (fall_cnt_reg + 5'h01 == len_clocks(len_now_reg)) begin
                sampling_o <= 1'b0;
                done_o <= 1'b0;
                // The start pulse is issued only here, after the last falling edge.
                start_reg <= 1'b1;
                chan_addr_o <= cmd_reg[`ASCP_ADDR_MSB:`ASCP_ADDR_LSB];
                powered_down_o <= (cmd_reg[7:4] == `ASCP_ADDR_PDOWN);
                state_reg <= ST_IDLE;
              end
              if (fall_cnt_reg + 5'h01 == 5'h0a) begin
                abort_win_reg <= 1'b1;
                abort_cnt_reg <= ABORT_CYC[15:0];
              end
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule

// *** ascp_port_asserts.sv ***
// Purpose: Timing checks on the converter's serial port pins.
// Assumes: One clock domain, reset synchronous and active high.
// Notes: Bound to the port module from the bench.
`timescale 1ns/1ps
module ascp_port_asserts #(
  parameter CONV_CYC = 100
) (
  // System.
  input wire clk_i,
  input wire rst_i,
  // Link pins.
  input wire sel_n_i,
  input wire sclk_i,
  input wire dout_o,
  input wire dout_oe_o,
  input wire done_o,
  // Conversion status.
  input wire [3:0] chan_addr_o,
  input wire powered_down_o,
  input wire sampling_o
);
  int low_cnt;
  always @(posedge clk_i) begin
    if (rst_i || done_o) low_cnt <= 0;
    else low_cnt <= low_cnt + 1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_conv_start;
    $fell(done_o);
  endsequence
  sequence s_conv_hold;
    !done_o [*8];
  endsequence
  a_reset_idle: assert property ($past(rst_i) |-> done_o && !dout_oe_o)
    else $error("bad state after reset");
  a_sel_high_off: assert property (sel_n_i [*5] |-> !dout_oe_o)
    else $error("output driven while deselected");
  a_sel_fall_on: assert property ($fell(sel_n_i) ##1 !sel_n_i [*5] |-> dout_oe_o)
    else $error("output not driven after select fall");
  a_conv_after_io: assert property (s_conv_start |-> !sclk_i && !sel_n_i)
    else $error("conversion began outside a last falling edge");
  a_conv_min_len: assert property (s_conv_start |-> s_conv_hold)
    else $error("conversion too short");
  a_conv_max_len: assert property (low_cnt <= CONV_CYC + 4)
    else $error("conversion too long");
  a_dout_on_fall: assert property (dout_oe_o && $past(dout_oe_o) && $changed(dout_o) |-> !sclk_i)
    else $error("result bit changed with clock high");
  a_sample_start: assert property ($rose(sampling_o) |-> !sclk_i)
    else $error("sampling began off a falling edge");
  a_sample_hold: assert property ($fell(sampling_o) |-> ##[0:1] !done_o)
    else $error("sampling ended without conversion");
  a_chan_hold: assert property (!done_o && !$past(done_o) |-> $stable(chan_addr_o))
    else $error("address changed in conversion");
  a_pd_code: assert property (powered_down_o |-> chan_addr_o == 4'he)
    else $error("power-down without its address");
endmodule

// *** ascp_host.sv ***
// Purpose: Host model driving select, shift clock and command input.
// Assumes: Shift clock period of eight system clocks, idle low.
// Notes: A released result line reads as the inverse of the driver.
`timescale 1ns/1ps
module ascp_host (
  // System.
  input wire clk_i,
  // Device pins.
  input wire dout_i,
  input wire dout_oe_i,
  input wire done_i,
  output logic sel_n_o,
  output logic sclk_o,
  output logic cmd_o
);
  wire line = dout_oe_i ? dout_i : ~dout_i;
  initial begin
    sel_n_o = 1'b1;
    sclk_o = 1'b0;
    cmd_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic stray();
    repeat (3) begin
      tick(4);
      sclk_o <= ~sclk_o;
      cmd_o <= ~cmd_o;
    end
    tick(4);
    sclk_o <= 1'b0;
  endtask
  // One I/O cycle; the bits read are shifted into rx from the right.
  task automatic xfer(input logic [7:0] cmd, input int n, input bit fall, input bit hold,
                      output logic [15:0] rx);
    rx = 16'h0000;
    for (int w = 0; w < 400 && done_i !== 1'b1; w++) tick(1);
    tick(2);
    if (fall) begin
      sel_n_o <= 1'b0;
      tick(12);
    end
    for (int i = 0; i < n; i++) begin
      cmd_o <= (i < 8) ? cmd[7 - i] : ~cmd_o;
      tick(4);
      sclk_o <= 1'b1;
      @(negedge clk_i);
      rx = {rx[14:0], line};
      tick(4);
      sclk_o <= 1'b0;
    end
    tick(6);
    if (!hold) sel_n_o <= 1'b1;
  endtask
endmodule

// *** test_ascp_port.sv ***
// Purpose: Self-checking bench for the converter's serial port.
// Assumes: Short conversion count; the host model makes the link clock.
// Notes: The first result after reset is discarded, as a host must.
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    checks++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("unexpected t=%0t got %h exp %h", $time, got, exp); \
    end \
  end
module test_ascp_port;
  localparam int CONV = 20;
  logic clk_i;
  logic rst_i = 1'b1;
  logic [11:0] sample_i = 12'h000;
  wire sel_n_i, sclk_i, cmd_i, dout_o, dout_oe_o, done_o, powered_down_o, sampling_o;
  wire [3:0] chan_addr_o;
  int err_total = 0;
  int checks = 0;
  logic [15:0] rx;
  logic [7:0] cmd_t [6] = '{8'h30, 8'h1c, 8'h2b, 8'he8, 8'h54, 8'hb0};
  int len_t [6] = '{12, 16, 12, 12, 8, 12};
  logic [11:0] smp_t [6] = '{12'ha5c, 12'h3c1, 12'h9e7, 12'h6b2, 12'h0f4, 12'h5a3};
  ascp_port #(
    .CONV_CYC(CONV),
    .SETUP_CYC(2),
    .ABORT_CYC(40)
  ) u_ascp_port (
    .clk_i(clk_i), .rst_i(rst_i), .sel_n_i(sel_n_i), .sclk_i(sclk_i), .cmd_i(cmd_i),
    .dout_o(dout_o), .dout_oe_o(dout_oe_o), .done_o(done_o), .sample_i(sample_i),
    .chan_addr_o(chan_addr_o), .powered_down_o(powered_down_o), .sampling_o(sampling_o)
  );
  ascp_host u_ascp_host (
    .clk_i(clk_i), .dout_i(dout_o), .dout_oe_i(dout_oe_o), .done_i(done_o),
    .sel_n_o(sel_n_i), .sclk_o(sclk_i), .cmd_o(cmd_i)
  );
  // Stream as shifted: the result formatted by its own command, cut to n bits.
  function automatic logic [15:0] fmt(logic [11:0] s, logic [7:0] c, int n);
    logic [11:0] r;
    r = {s[11] ^ c[0], s[10:0]};
    if (c[1]) r = {<<{r}};
    return {r, 4'h0} >> (16 - n);
  endfunction
  task automatic give_verdict();
    if (err_total == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    #1000000;
    err_total++;
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    `CHK(done_o, 1'b1)
    u_ascp_host.stray();
    @(negedge clk_i);
    `CHK(dout_oe_o, 1'b0)
    `CHK(done_o, 1'b1)
    for (int k = 0; k < 6; k++) begin
      @(posedge clk_i);
      sample_i <= smp_t[k];
      u_ascp_host.xfer(cmd_t[k], len_t[k], k != 5, k == 4, rx);
      @(negedge clk_i);
      if (k > 0) `CHK(rx, fmt(smp_t[k - 1], cmd_t[k - 1], len_t[k]))
      `CHK(done_o, 1'b0)
      `CHK(sampling_o, 1'b0)
      `CHK(chan_addr_o, cmd_t[k][7:4])
      `CHK(powered_down_o, cmd_t[k][7:4] == 4'he)
    end
    // A select fall shortly after the last edge, inside the window, aborts the conversion.
    u_ascp_host.xfer(8'h30, 12, 1'b1, 1'b0, rx);
    repeat (6) @(posedge clk_i);
    u_ascp_host.sel_n_o <= 1'b0;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    `CHK(done_o, 1'b1)
    give_verdict();
  end
endmodule
bind ascp_port ascp_port_asserts #(.CONV_CYC(CONV_CYC)) u_ascp_port_asserts (
  .clk_i(clk_i), .rst_i(rst_i), .sel_n_i(sel_n_i), .sclk_i(sclk_i), .dout_o(dout_o),
  .dout_oe_o(dout_oe_o), .done_o(done_o), .chan_addr_o(chan_addr_o),
  .powered_down_o(powered_down_o), .sampling_o(sampling_o)
);
